// ==== ssr_top.v ====
/*
 * Conversion sequencing and serial readout of a 14-bit differential
 * successive-approximation converter, plus a buffer of finished words.
 * Assumes the frame select and serial clock pins arrive asynchronously
 * and are much slower than clk_i (serial clock period >= 8 clk_i cycles);
 * ain_code_i is the front end's two's complement view of the input,
 * produced on clk_i.
 * Pin edges are seen three clk_i cycles after the pin moves; a serial
 * clock phase shorter than one clk_i cycle can be missed and would slip
 * the bit count. The link has no reset of its own: a frame select
 * rise is the only way to cut a running conversion short.
 * A word that finishes while the buffer and its hand-off stage are
 * both full is dropped and flagged on overrun_o, since the link
 * cannot be made to wait.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ssr_regs.vh"

module ssr_top #(
  parameter RES_W = `SSR_RES_W,
  parameter FIFO_DEPTH = `SSR_FIFO_DEPTH,
  parameter FIFO_AW = `SSR_FIFO_AW
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire cs_n_i,
  input wire sclk_i,
  input wire [RES_W-1:0] ain_code_i,
  output wire dout_o,
  output wire dout_oe_o,
  output wire track_o,
  output wire hold_o,
  output wire frame_done_o,
  output wire overrun_o,
  output wire res_valid_o,
  input wire res_ready_i,
  output wire [RES_W-1:0] res_data_o
);

  localparam ST_TRACK = 1'b0;
  localparam ST_CONV = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  reg cs_meta_ff;
  reg cs_sync_ff;
  reg cs_prev_ff;
  reg sclk_meta_ff;
  reg sclk_sync_ff;
  reg sclk_prev_ff;

  // both pins come from the controller's side, not from clk_i
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      cs_meta_ff <= 1'b1;
      cs_sync_ff <= 1'b1;
      cs_prev_ff <= 1'b1;
      sclk_meta_ff <= 1'b0;
      sclk_sync_ff <= 1'b0;
      sclk_prev_ff <= 1'b0;
    end else begin
      cs_meta_ff <= cs_n_i;
      cs_sync_ff <= cs_meta_ff;
      cs_prev_ff <= cs_sync_ff;
      sclk_meta_ff <= sclk_i;
      sclk_sync_ff <= sclk_meta_ff;
      sclk_prev_ff <= sclk_sync_ff;
    end
  end

  wire cs_fall = cs_prev_ff && !cs_sync_ff;
  wire cs_rise = !cs_prev_ff && cs_sync_ff;
  wire sclk_fall = sclk_prev_ff && !sclk_sync_ff;

  ////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  reg state_ff;
  reg nxt_state;
  reg [`SSR_CNT_W-1:0] edge_cnt_ff;
  reg [`SSR_CNT_W-1:0] nxt_edge_cnt;
  reg [RES_W-1:0] held_ff;
  reg [RES_W-1:0] nxt_held;
  reg [RES_W-1:0] sar_ff;
  reg [RES_W-1:0] nxt_sar;
  reg [RES_W-1:0] wt_ff;
  reg [RES_W-1:0] nxt_wt;
  reg dout_ff;
  reg nxt_dout;
  reg dout_oe_ff;
  reg nxt_dout_oe;
  reg done_ff;
  reg nxt_done;
  reg [RES_W-1:0] trial;
  reg bit_val;
  reg decide;
  reg track_ff;
  reg hold_ff;

  always @* begin
    nxt_state = state_ff;
    nxt_edge_cnt = edge_cnt_ff;
    nxt_held = held_ff;
    nxt_sar = sar_ff;
    nxt_wt = wt_ff;
    nxt_dout = dout_ff;
    nxt_dout_oe = dout_oe_ff;
    nxt_done = 1'b0;
    decide = 1'b0;
    trial = sar_ff | wt_ff;
    // offset-binary comparison of held sample against trial level
    bit_val = (held_ff >= trial);
    case (state_ff)
      ST_TRACK: begin
        // serial clock falls while tracking are ignored
        if (cs_rise) begin
          // a frame that ran to completion ends here
          nxt_dout_oe = 1'b0;
          nxt_edge_cnt = `SSR_CNT_ZERO;
        end else if (cs_fall) begin
          // capture, flipping the sign bit into offset-binary for the search
          nxt_held = {~ain_code_i[RES_W-1], ain_code_i[RES_W-2:0]};
          nxt_sar = `SSR_ZERO_CODE;
          nxt_wt = `SSR_FIRST_WT;
          nxt_state = ST_CONV;
          nxt_dout_oe = 1'b1;
          nxt_dout = 1'b0;
          // clock already low at frame start counts as the first falling edge
          nxt_edge_cnt = sclk_sync_ff ? `SSR_CNT_ZERO : `SSR_CNT_ONE;
        end
      end
      ST_CONV: begin
        if (cs_rise) begin
          // cut short: the running conversion is dropped, nothing stored
          nxt_state = ST_TRACK;
          nxt_dout_oe = 1'b0;
          nxt_edge_cnt = `SSR_CNT_ZERO;
        end else if (sclk_fall) begin
          nxt_edge_cnt = edge_cnt_ff + `SSR_CNT_INC;
          // edges three to sixteen each settle one result bit
          decide = (nxt_edge_cnt >= `SSR_MSB_EDGE) &&
            (nxt_edge_cnt <= `SSR_TRACK_EDGE);
          if (decide) begin
            nxt_sar = bit_val ? trial : sar_ff;
            nxt_wt = wt_ff >> 1;
            // send the sign bit in two's complement form
            nxt_dout = (wt_ff == `SSR_FIRST_WT) ? ~bit_val : bit_val;
          end
          if (nxt_edge_cnt == `SSR_TRACK_EDGE) begin
            nxt_state = ST_TRACK;
            nxt_done = 1'b1;
          end
        end
      end
      default: begin
        // unreachable with a one-bit state; keeps the case complete
        nxt_state = ST_TRACK;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_TRACK;
      edge_cnt_ff <= `SSR_CNT_ZERO;
      dout_oe_ff <= 1'b0;
      done_ff <= 1'b0;
      track_ff <= 1'b1;
      hold_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      edge_cnt_ff <= nxt_edge_cnt;
      dout_oe_ff <= nxt_dout_oe;
      done_ff <= nxt_done;
      // mode pins come from their own flops, not from a decode of state
      track_ff <= (nxt_state == ST_TRACK);
      hold_ff <= (nxt_state == ST_CONV);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sample and search registers
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      held_ff <= `SSR_ZERO_CODE;
      sar_ff <= `SSR_ZERO_CODE;
      wt_ff <= `SSR_ZERO_CODE;
      dout_ff <= 1'b0;
    end else begin
      // sample register only moves at frame start: input isolated
      held_ff <= nxt_held;
      sar_ff <= nxt_sar;
      wt_ff <= nxt_wt;
      dout_ff <= nxt_dout;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result hand-off into the buffer

  reg [RES_W-1:0] pend_data_ff;
  reg pend_ff;
  reg overrun_ff;
  wire fifo_in_ready;
  wire [RES_W-1:0] done_word;

  // nxt_sar holds the finished code on the completing edge
  assign done_word = {~nxt_sar[RES_W-1], nxt_sar[RES_W-2:0]};

  // a full buffer stalls the hand-off; a second word while stalled is lost
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      pend_data_ff <= `SSR_ZERO_CODE;
      pend_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end else begin
      if (nxt_done && (!pend_ff || fifo_in_ready)) begin
        pend_data_ff <= done_word;
        pend_ff <= 1'b1;
      end else if (pend_ff && fifo_in_ready) begin
        pend_ff <= 1'b0;
      end
      if (nxt_done && pend_ff && !fifo_in_ready) begin
        overrun_ff <= 1'b1;
      end
    end
  end

  wire fifo_out_valid;
  wire [RES_W-1:0] fifo_out_data;
  reg res_valid_ff;
  reg [RES_W-1:0] res_data_ff;
  wire take;

  ssr_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(pend_ff),
    .in_ready_o(fifo_in_ready),
    .in_data_i(pend_data_ff),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(take),
    .out_data_o(fifo_out_data)
  );

  // output register stage so the result port comes from flops
  assign take = fifo_out_valid && (!res_valid_ff || res_ready_i);

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      res_valid_ff <= 1'b0;
      res_data_ff <= `SSR_ZERO_CODE;
    end else begin
      if (take) begin
        res_valid_ff <= 1'b1;
        res_data_ff <= fifo_out_data;
      end else if (res_ready_i) begin
        res_valid_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign dout_o = dout_ff;
  assign dout_oe_o = dout_oe_ff;
  assign track_o = track_ff;
  assign hold_o = hold_ff;
  assign frame_done_o = done_ff;
  assign overrun_o = overrun_ff;
  assign res_valid_o = res_valid_ff;
  assign res_data_o = res_data_ff;

endmodule
`default_nettype wire

// ==== ssr_regs.vh ====
/*
 * Constants for the serial readout of the 14-bit sampling converter:
 * result width, falling-edge positions inside a frame and buffer depth.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SSR_REGS_VH
`define SSR_REGS_VH

// result word
`define SSR_RES_W 14
`define SSR_RES_MSB 13
// offset-binary weight of the first trial bit
`define SSR_FIRST_WT 14'h2000
`define SSR_ZERO_CODE 14'h0000

// falling-edge counter inside a frame
`define SSR_CNT_W 5
`define SSR_CNT_ZERO 5'h00
`define SSR_CNT_ONE 5'h01
`define SSR_CNT_INC 5'h01
// edge that carries the most significant bit out
`define SSR_MSB_EDGE 5'h03
// edge that finishes the conversion and returns to tracking
`define SSR_TRACK_EDGE 5'h10
// clock periods per full frame the controller must give
`define SSR_FRAME_CYC 5'h12

// result buffer
`define SSR_FIFO_W 14
`define SSR_FIFO_DEPTH 16
`define SSR_FIFO_AW 4

`endif

// ==== ssr_fifo.v ====
/*
 * Synchronous FIFO for finished conversion words.
 * Assumes writer and reader share clk_i; width and depth are parameters,
 * depth a power of two of 2**AW entries.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ssr_regs.vh"

module ssr_fifo #(
  parameter WIDTH = `SSR_FIFO_W,
  parameter DEPTH = `SSR_FIFO_DEPTH,
  parameter AW = `SSR_FIFO_AW
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  reg full_ff;
  reg empty_ff;
  reg [AW:0] nxt_count;
  wire push;
  wire pop;

  assign push = in_valid_i && !full_ff;
  assign pop = out_valid_o && out_ready_i;
  assign in_ready_o = !full_ff;
  assign out_valid_o = !empty_ff;
  assign out_data_o = mem[rd_ptr_ff];

  always @* begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + {{AW{1'b0}}, 1'b1};
    end else if (pop && !push) begin
      nxt_count = count_ff - {{AW{1'b0}}, 1'b1};
    end
  end

  // storage has no reset; only pointers, count and flags need a defined value
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
      full_ff <= 1'b0;
      empty_ff <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      count_ff <= nxt_count;
      full_ff <= (nxt_count == DEPTH[AW:0]);
      empty_ff <= (nxt_count == {(AW+1){1'b0}});
    end
  end

endmodule
`default_nettype wire

// ==== ssr_top_checker.sv ====
/* Assertions on the ports of ssr_top.
   Assumes a serial clock of 8 clk_i cycles per period, 4 high, 4 low. */
`timescale 1ns/1ns
`default_nettype none
module ssr_top_checker #(parameter RES_W = 14) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic track_o,
  input wire logic hold_o,
  input wire logic frame_done_o,
  input wire logic overrun_o,
  input wire logic res_valid_o,
  input wire logic res_ready_i,
  input wire logic [RES_W-1:0] res_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // six cycles covers the two sync flops and the detector
  a_oe_cs_high: assert property (cs_n_i [*6] |-> !dout_oe_o)
    else $error("oe high");
  a_hold_start: assert property ($rose(hold_o) |-> dout_oe_o && !dout_o)
    else $error("bad start");
  a_mode_excl: assert property (track_o ^ hold_o)
    else $error("mode clash");
  a_done_track: assert property (frame_done_o |-> track_o && $past(hold_o))
    else $error("bad done");
  a_done_pulse: assert property (frame_done_o |=> !frame_done_o)
    else $error("long done");
  a_dout_sclk: assert property (dout_oe_o && $past(dout_oe_o) && $changed(dout_o)
    |-> !$past(sclk_i) && $past(sclk_i, 5))
    else $error("dout moved off sclk fall");
  a_res_hold: assert property (res_valid_o && !res_ready_i
    |=> res_valid_o && $stable(res_data_o))
    else $error("word dropped");
  a_res_after_done: assert property ($rose(res_valid_o) |-> $past(frame_done_o, 2))
    else $error("stray word");
  a_ovr_sticky: assert property (overrun_o |=> overrun_o)
    else $error("overrun cleared");
endmodule
//////////////////////////////////////////////////////////////////////
bind ssr_top ssr_top_checker #(.RES_W(RES_W)) u_chk (
  .clk_i(clk_i),
  .reset_n_i(reset_n_i),
  .cs_n_i(cs_n_i),
  .sclk_i(sclk_i),
  .dout_o(dout_o),
  .dout_oe_o(dout_oe_o),
  .track_o(track_o),
  .hold_o(hold_o),
  .frame_done_o(frame_done_o),
  .overrun_o(overrun_o),
  .res_valid_o(res_valid_o),
  .res_ready_i(res_ready_i),
  .res_data_o(res_data_o)
);
`default_nettype wire

// ==== ssr_host_model.sv ====
/* Link controller model: frame select, serial clock, bit capture.
   Assumes frames are started by hierarchical calls of frame(). */
`timescale 1ns/1ns
`default_nettype none
module ssr_host_model (
  input wire logic clk_i,
  input wire logic dout_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [13:0] word_o,
  output logic whole_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    word_o = 14'h0000;
    whole_o = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  // n periods; an idle-low clock makes the select fall count as edge 1
  task automatic frame(input int n, input int half, input logic idle);
    int k;
    sclk_o = idle;
    step(4);
    cs_n_o = 1'b0;
    k = idle ? 0 : 1;
    step(half);
    for (int i = 0; i < n; i++) begin
      if (sclk_o) begin
        sclk_o = 1'b0;
        k++;
        step(half);
      end
      sclk_o = 1'b1;
      if (k >= 3 && k <= 16) word_o = {word_o[12:0], dout_i};
      step(half);
    end
    cs_n_o = 1'b1;
    whole_o = (k >= 16);
    step(8);
  endtask
endmodule
`default_nettype wire

// ==== ssr_top_bench.sv ====
/* Self-checking bench for ssr_top.
   Assumes ssr_host_model on the link and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module ssr_top_bench;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [13:0] ain_code_i = 14'h0000;
  logic res_ready_i = 1'b0;
  wire logic cs_n, sclk, dout, dout_oe, track, hold, done, overrun, res_valid, whole;
  wire logic [13:0] res_data, word;
  // released pin shows the inverse, never a stale level
  wire logic dout_pin = dout_oe ? dout : ~dout;
  int fails = 0;
  int comparisons = 0;
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  ssr_top u_dut (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .cs_n_i(cs_n),
    .sclk_i(sclk),
    .ain_code_i(ain_code_i),
    .dout_o(dout),
    .dout_oe_o(dout_oe),
    .track_o(track),
    .hold_o(hold),
    .frame_done_o(done),
    .overrun_o(overrun),
    .res_valid_o(res_valid),
    .res_ready_i(res_ready_i),
    .res_data_o(res_data)
  );
  ssr_host_model u_host (
    .clk_i(clk_i),
    .dout_i(dout_pin),
    .cs_n_o(cs_n),
    .sclk_o(sclk),
    .word_o(word),
    .whole_o(whole)
  );
  //////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [13:0] seen, input logic [13:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task pop(input logic [13:0] exp);
    int n;
    n = 0;
    while (res_valid !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      #2;
      n++;
    end
    if (n == 400) begin
      fails++;
      stop_test();
    end else begin
      chk("res_data", res_data, exp);
      res_ready_i = 1'b1;
      @(posedge clk_i);
      #2 res_ready_i = 1'b0;
    end
  endtask
  // both idle levels of the serial clock, input moved mid-conversion
  task t_full;
    logic [13:0] codes [4];
    codes = '{14'h1fff, 14'h2000, 14'h0000, 14'h2aaa};
    for (int i = 0; i < 4; i++) begin
      ain_code_i = codes[i];
      fork
        u_host.frame(18, 4, i < 2);
        begin
          repeat (30) @(posedge clk_i);
          #2 ain_code_i = ~codes[i];
        end
      join
      chk("word", word, codes[i]);
      chk("track", 14'(track), 14'h0001);
      chk("whole", 14'(whole), 14'h0001);
      pop(codes[i]);
    end
    $display("full frames done");
  endtask
  task t_cut;
    u_host.frame(10, 4, 1'b1);
    repeat (20) @(posedge clk_i);
    #2;
    chk("valid", 14'(res_valid), 14'h0000);
    chk("oe", 14'(dout_oe), 14'h0000);
    chk("track", 14'(track), 14'h0001);
    chk("hold", 14'(hold), 14'h0000);
    chk("whole", 14'(whole), 14'h0000);
    chk("overrun", 14'(overrun), 14'h0000);
    $display("cut frame done");
  endtask
  // 18 words fit; the 19th is lost while the consumer stalls
  task t_fill;
    for (int i = 0; i < 19; i++) begin
      ain_code_i = 14'(i + 256);
      u_host.frame(18, 4, 1'b1);
    end
    chk("overrun", 14'(overrun), 14'h0001);
    for (int i = 0; i < 18; i++) pop(14'(i + 256));
    repeat (4) @(posedge clk_i);
    #2;
    chk("valid", 14'(res_valid), 14'h0000);
    $display("fill and drain done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    #2 reset_n_i = 1'b1;
    t_full();
    t_cut();
    t_fill();
    stop_test();
  end
endmodule
`default_nettype wire
